/* File: ctb_pkg.sv */
// Shared constants, types and carriers for the console typewriter buffer.
// Assumes one 250 MHz system clock and a synchronous active-low reset.
`default_nettype none

package ctb_pkg;

  // Character and buffer geometry
  localparam int CTB_CHAR_W     = 6;
  localparam int CTB_AR_W       = 4;
  localparam int CTB_FIFO_DEPTH = 8;

  // Print cycle timing: ten characters per second
  localparam int CTB_CLK_HZ       = 250_000_000;
  localparam int CTB_CHAR_RATE_HZ = 10;
  localparam int CTB_PRINT_CYCLES = CTB_CLK_HZ / CTB_CHAR_RATE_HZ;
  localparam int CTB_TIMER_W      = 25;

  // Reset value of the typed-character buffer
  localparam logic [5:0] CTB_TBR_RESET = 6'h00;

  // Nonprinting control codes, zone in bits 5:4, numeric in 3:0
  localparam logic [5:0] CTB_CODE_CRLF = 6'h13;
  localparam logic [5:0] CTB_CODE_BELL = 6'h23;
  localparam logic [5:0] CTB_CODE_HTAB = 6'h2E;
  localparam logic [5:0] CTB_CODE_FORM = 6'h3E;

  // Processor operations handed to the block
  typedef enum logic [2:0] {
    CTB_OP_NONE,
    CTB_OP_PRINT,
    CTB_OP_ARM,
    CTB_OP_FETCH,
    CTB_OP_CLR_TYPE,
    CTB_OP_CLR_REQ,
    CTB_OP_CLR_REL
  } ctb_op_type;

  typedef struct packed {
    logic [1:0] zone;
    logic [3:0] numeric;
  } ctb_char_type;

  typedef struct packed {
    logic                valid;
    ctb_op_type          op;
    ctb_char_type        ch;
    logic [CTB_AR_W-1:0] ar_sel;
  } ctb_cmd_type;

  typedef struct packed {
    logic crlf;
    logic bell;
    logic htab;
    logic form;
  } ctb_ctrl_type;

  typedef struct packed {
    logic type_done;
    logic key_request;
    logic key_release;
  } ctb_ind_type;

endpackage

`default_nettype wire

/* File: ctb_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides.
// Assumes the same clock and reset as the block that owns it.
`default_nettype none

module ctb_fifo #(
  parameter int WIDTH = 6,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_sys_in,
  input  wire logic             rst_n_in,
  input  wire logic             in_valid_in,
  output var  logic             in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output var  logic             out_valid_out,
  input  wire logic             out_ready_in,
  output var  logic [WIDTH-1:0] out_data_out
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW:0]      wr_ptr_q;
  logic [PW:0]      rd_ptr_q;
  logic             push;
  logic             pop;
  logic             full;
  logic             empty;

  // Extra pointer bit tells full from empty
  assign full          = (wr_ptr_q[PW] != rd_ptr_q[PW]) && (wr_ptr_q[PW-1:0] == rd_ptr_q[PW-1:0]);
  assign empty         = (wr_ptr_q == rd_ptr_q);
  assign push          = in_valid_in && !full;
  assign pop           = out_ready_in && !empty;
  assign in_ready_out  = !full;
  assign out_valid_out = !empty;
  assign out_data_out  = mem_q[rd_ptr_q[PW-1:0]];

  // Storage is written only on an accepted push
  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem_q[wr_ptr_q[PW-1:0]] <= in_data_in;
    end
  end

  // Pointers
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push) wr_ptr_q <= wr_ptr_q + 1'b1;
      if (pop)  rd_ptr_q <= rd_ptr_q + 1'b1;
    end
  end

endmodule // ctb_fifo

`default_nettype wire

/* File: ctb_print_timer.sv */
// Print cycle timer: one start pulse, busy for CYCLES clocks, then a done pulse.
// Assumes the owner never starts it while busy.
`default_nettype none

module ctb_print_timer
  import ctb_pkg::*;
#(
  parameter int CYCLES = CTB_PRINT_CYCLES
) (
  input  wire logic clk_sys_in,
  input  wire logic rst_n_in,
  input  wire logic start_in,
  output var  logic busy_out,
  output var  logic done_out
);

  localparam logic [CTB_TIMER_W-1:0] LOAD = CTB_TIMER_W'(CYCLES - 1);

  logic [CTB_TIMER_W-1:0] count_q;

  // Count down while the print mechanism is in motion
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      count_q  <= '0;
      busy_out <= 1'b0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (start_in && !busy_out) begin
        count_q  <= LOAD;
        busy_out <= 1'b1;
      end else if (busy_out) begin
        if (count_q == '0) begin
          busy_out <= 1'b0;
          done_out <= 1'b1;
        end else begin
          count_q <= count_q - 1'b1;
        end
      end
    end
  end

endmodule // ctb_print_timer

`default_nettype wire

/* File: ctb_typewriter.sv */
// Console typewriter buffer: six-bit character register between processor and typewriter.
// Assumes operator pins are asynchronous and processor commands are synchronous to clk_sys_in.
`default_nettype none

// How it works
// - Every character in or out passes one at a time through the six-bit typed_char_buffer.
// - A print_char_op issued while no print cycle runs loads the buffer from the command and starts one without stalling the processor.
// - The end of a print cycle sets the typewriter indicator and raises the contingency output.
// - The request button sets the request indicator and raises the contingency output.
// - A keyboard_arm_op arms the keyboard for exactly one character while the processor runs on.
// - A keyed character disarms the keyboard and sets the typewriter indicator.
// - A fetch_typed_char_op copies the buffer to the designated arithmetic register.
// - While on-line a keystroke only loads the buffer and never prints.
// - The release button sets the release indicator and raises the contingency output.
// - Characters are two zone bits and four numeric bits, with four decoded nonprinting controls.
// - The request button does nothing while the typewriter is off-line.
// - The keyboard-active lamp lights on arming and goes out on a keystroke or a release.
// - A print cycle lasts one tenth of a second.
module ctb_typewriter
  import ctb_pkg::*;
#(
  parameter int PRINT_CYCLES = CTB_PRINT_CYCLES
) (
  input  wire logic                clk_sys_in,
  input  wire logic                rst_n_in,
  input  wire ctb_cmd_type         cmd_in,
  input  wire logic                online_in,
  input  wire logic                key_strobe_in,
  input  wire logic [5:0]          key_char_in,
  input  wire logic                req_btn_in,
  input  wire logic                rel_btn_in,
  output var  logic                key_ready_out,
  output var  logic                print_strobe_out,
  output var  ctb_char_type        print_char_out,
  output var  ctb_ctrl_type        print_ctrl_out,
  output var  logic                print_busy_out,
  output var  logic                fetch_valid_out,
  output var  ctb_char_type        fetch_char_out,
  output var  logic [CTB_AR_W-1:0] fetch_ar_out,
  output var  logic                keyboard_active_out,
  output var  ctb_ind_type         indicators_out,
  output var  logic                contingency_out
);

  typedef enum logic {CTB_KB_IDLE, CTB_KB_ARMED} ctb_kb_state_type;

  // Pin synchroniser: strobe, request, release, online, then the character
  localparam int SW = 4 + CTB_CHAR_W;

  logic [SW-1:0]    sync1_q;
  logic [SW-1:0]    sync2_q;
  logic [2:0]       last_q;
  ctb_kb_state_type kb_q;
  ctb_kb_state_type kb_d;
  ctb_char_type     tbr_q;
  ctb_ind_type      ind_q;
  ctb_ind_type      ind_d;
  ctb_ind_type      ind_set;
  ctb_ind_type      ind_clr;
  logic             key_edge;
  logic             req_edge;
  logic             rel_edge;
  logic             online_s;
  logic [5:0]       key_char_s;
  logic             fifo_in_ready;
  logic             fifo_out_valid;
  logic [5:0]       fifo_out_data;
  logic             drain;
  logic             print_take;
  logic             fetch_take;
  logic             arm_take;
  logic             timer_busy;
  logic             timer_done;

  // Two flops on every pin before logic sees it
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {key_strobe_in, req_btn_in, rel_btn_in, online_in, key_char_in};
      sync2_q <= sync1_q;
    end
  end

  // Edge history for the three button-like pins
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      last_q <= 3'h0;
    end else begin
      last_q <= sync2_q[SW-1 -: 3];
    end
  end

  // Rising edges only; a held key or button counts once
  assign key_edge   = sync2_q[SW-1] && !last_q[2];
  assign req_edge   = sync2_q[SW-2] && !last_q[1];
  assign rel_edge   = sync2_q[SW-3] && !last_q[0];
  assign online_s   = sync2_q[SW-4];
  assign key_char_s = sync2_q[CTB_CHAR_W-1:0];

  // Command decode; a print while the mechanism moves is ignored
  assign print_take = cmd_in.valid && (cmd_in.op == CTB_OP_PRINT) && !timer_busy;
  assign fetch_take = cmd_in.valid && (cmd_in.op == CTB_OP_FETCH);
  assign arm_take   = cmd_in.valid && (cmd_in.op == CTB_OP_ARM);
  assign ind_clr.type_done   = cmd_in.valid && (cmd_in.op == CTB_OP_CLR_TYPE);
  assign ind_clr.key_request = cmd_in.valid && (cmd_in.op == CTB_OP_CLR_REQ);
  assign ind_clr.key_release = cmd_in.valid && (cmd_in.op == CTB_OP_CLR_REL);

  // Keystrokes queue until armed; a print load that cycle takes the buffer first
  assign drain = (kb_q == CTB_KB_ARMED) && fifo_out_valid && !print_take;

  // Indicator sources
  assign ind_set.type_done   = timer_done || drain;
  assign ind_set.key_request = req_edge && online_s;
  assign ind_set.key_release = rel_edge;

  // Set beats a clear landing in the same cycle
  assign ind_d = (ind_q & ~ind_clr) | ind_set;

  // Offline keystrokes belong to the plain typewriter and never reach the buffer
  ctb_fifo #(
    .WIDTH (CTB_CHAR_W),
    .DEPTH (CTB_FIFO_DEPTH)
  ) u_key_fifo (
    .clk_sys_in    (clk_sys_in),
    .rst_n_in      (rst_n_in),
    .in_valid_in   (key_edge && online_s),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (key_char_s),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (drain),
    .out_data_out  (fifo_out_data)
  );

  ctb_print_timer #(
    .CYCLES (PRINT_CYCLES)
  ) u_print_timer (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .start_in   (print_take),
    .busy_out   (timer_busy),
    .done_out   (timer_done)
  );

  // Keyboard arming: one character per arm, release also disarms
  always_comb begin
    kb_d = kb_q;
    case (kb_q)
      CTB_KB_IDLE: begin
        if (arm_take && !rel_edge) kb_d = CTB_KB_ARMED;
      end
      CTB_KB_ARMED: begin
        if (drain || rel_edge) kb_d = CTB_KB_IDLE;
      end
      default: kb_d = CTB_KB_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      kb_q <= CTB_KB_IDLE;
    end else begin
      kb_q <= kb_d;
    end
  end

  // The one buffer register; fetches only read it
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      tbr_q <= CTB_TBR_RESET;
    end else if (print_take) begin
      tbr_q <= cmd_in.ch;
    end else if (drain) begin
      tbr_q <= fifo_out_data;
    end
  end

  // Indicators and the combined contingency request
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      ind_q           <= '0;
      contingency_out <= 1'b0;
    end else begin
      ind_q           <= ind_d;
      contingency_out <= |ind_d;
    end
  end

  // Printer drive: a one-cycle strobe with the character and its control decode
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      print_strobe_out <= 1'b0;
      print_char_out   <= '0;
      print_ctrl_out   <= '0;
    end else begin
      print_strobe_out <= print_take;
      if (print_take) begin
        print_char_out      <= cmd_in.ch;
        print_ctrl_out.crlf <= (cmd_in.ch == CTB_CODE_CRLF);
        print_ctrl_out.bell <= (cmd_in.ch == CTB_CODE_BELL);
        print_ctrl_out.htab <= (cmd_in.ch == CTB_CODE_HTAB);
        print_ctrl_out.form <= (cmd_in.ch == CTB_CODE_FORM);
      end
    end
  end

  // Fetch answer to the arithmetic register file
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      fetch_valid_out <= 1'b0;
      fetch_char_out  <= '0;
      fetch_ar_out    <= '0;
    end else begin
      fetch_valid_out <= fetch_take;
      if (fetch_take) begin
        fetch_char_out <= tbr_q;
        fetch_ar_out   <= cmd_in.ar_sel;
      end
    end
  end

  // Status mirrors; key_ready lags the FIFO by one cycle, so the source keeps one spare slot
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      key_ready_out  <= 1'b0;
      print_busy_out <= 1'b0;
    end else begin
      key_ready_out  <= fifo_in_ready;
      print_busy_out <= timer_busy;
    end
  end

  assign keyboard_active_out = (kb_q == CTB_KB_ARMED);
  assign indicators_out      = ind_q;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_drain;
    drain;
  endsequence

  sequence s_print_start;
    print_take ##1 print_strobe_out;
  endsequence

  chk_print_load: assert property (
    print_take |=> print_strobe_out && (tbr_q == $past(cmd_in.ch)) && timer_busy)
    else $error("print load did not fill buffer and start cycle");

  chk_print_done: assert property (
    timer_done |=> ind_q.type_done && contingency_out)
    else $error("print completion did not set indicator");

  chk_key_disarm: assert property (
    s_drain |=> !keyboard_active_out && ind_q.type_done && !print_strobe_out)
    else $error("keystroke did not disarm and flag");

  chk_fetch_copy: assert property (
    fetch_take |=> fetch_valid_out && (fetch_char_out == $past(tbr_q)) && $stable(tbr_q))
    else $error("fetch did not copy buffer");

  chk_req_offline: assert property (
    req_edge && !online_s && !ind_q.key_request |=> !ind_q.key_request)
    else $error("request accepted while off-line");

  chk_release_lamp: assert property (
    rel_edge |=> !keyboard_active_out && ind_q.key_release && contingency_out)
    else $error("release did not turn lamp off");

  chk_sticky_hold: assert property (
    ind_q.key_request && !ind_clr.key_request |=> ind_q.key_request)
    else $error("indicator dropped without clear");

  chk_ctrl_decode: assert property (
    print_take && (cmd_in.ch == CTB_CODE_FORM) |=> print_ctrl_out.form && !print_ctrl_out.crlf)
    else $error("form feed not decoded");

  chk_print_span: assert property (
    s_print_start |-> timer_busy [*2])
    else $error("print cycle ended too early");

  // Lamp on arming, clears that take effect, and the interrupt summary
  chk_arm_lamp: assert property (
    arm_take && (kb_q == CTB_KB_IDLE) && !rel_edge |=> keyboard_active_out)
    else $error("keyboard arm did not light lamp");

  chk_clear_drop: assert property (
    ind_clr.type_done && !ind_set.type_done |=> !ind_q.type_done)
    else $error("indicator clear did not take effect");

  chk_flag_raise: assert property (
    contingency_out == (|ind_q))
    else $error("contingency output disagrees with indicators");

endmodule // ctb_typewriter

`default_nettype wire

/* File: ctb_console_model.sv */
// Behavioural console typewriter: keyboard, request and release buttons, printer.
// Assumes the bench clock; every pin changes 1 ns after a rising edge.
`default_nettype none

module ctb_console_model (
  input  wire logic       clk_sys_in,
  input  wire logic       print_strobe_in,
  output var  logic       key_strobe_out,
  output var  logic [5:0] key_char_out,
  output var  logic       req_btn_out,
  output var  logic       rel_btn_out
);
  timeunit 1ns;
  timeprecision 1ps;

  int prints = 0;

  // Strobe and button pins idle low, character lines at 6'h2A, until the bench asks for a keystroke or a button
  initial begin
    key_strobe_out = 1'b0;
    key_char_out = 6'h2A;
    req_btn_out = 1'b0;
    rel_btn_out = 1'b0;
  end

  // The printer only acts on a print strobe, never on a keystroke
  always @(posedge clk_sys_in) begin
    if (print_strobe_in === 1'b1) begin
      prints <= prints + 1;
    end
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask

  // One keystroke: character settles before the strobe, strobe low gap after
  task automatic key(input logic [5:0] ch);
    key_char_out = ch;
    wait_cyc(3);
    key_strobe_out = 1'b1;
    wait_cyc(4);
    key_strobe_out = 1'b0;
    key_char_out = ~ch; // Lines float after release, so show a changed value
    wait_cyc(4);
  endtask

  // One press of the request (rel=0) or release (rel=1) button
  task automatic press(input bit rel);
    req_btn_out = !rel;
    rel_btn_out = rel;
    wait_cyc(4);
    req_btn_out = 1'b0;
    rel_btn_out = 1'b0;
    wait_cyc(4);
  endtask
endmodule // ctb_console_model

`default_nettype wire

/* File: test_ctb_typewriter.sv */
// Self-checking bench for the console typewriter buffer, short print cycle.
// Assumes the console model drives keyboard and buttons; bench drives commands.
`default_nettype none

module test_ctb_typewriter
  import ctb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int P = 20;

  logic                clk_sys_in;
  logic                rst_n_in;
  ctb_cmd_type         cmd_in;
  logic                online_in;
  logic                key_strobe_in;
  logic [5:0]          key_char_in;
  logic                req_btn_in;
  logic                rel_btn_in;
  logic                key_ready_out;
  logic                print_strobe_out;
  ctb_char_type        print_char_out;
  ctb_ctrl_type        print_ctrl_out;
  logic                print_busy_out;
  logic                fetch_valid_out;
  ctb_char_type        fetch_char_out;
  logic [CTB_AR_W-1:0] fetch_ar_out;
  logic                keyboard_active_out;
  ctb_ind_type         indicators_out;
  logic                contingency_out;
  int                  n_errors = 0;
  int                  comparisons = 0;
  logic [5:0]          buf_m;
  logic [5:0]          kq[$];

  ctb_typewriter #(.PRINT_CYCLES(P)) i_ctb_typewriter (.clk_sys_in, .rst_n_in, .cmd_in, .online_in,
    .key_strobe_in, .key_char_in, .req_btn_in, .rel_btn_in, .key_ready_out, .print_strobe_out,
    .print_char_out, .print_ctrl_out, .print_busy_out, .fetch_valid_out, .fetch_char_out,
    .fetch_ar_out, .keyboard_active_out, .indicators_out, .contingency_out);

  ctb_console_model i_console (.clk_sys_in(clk_sys_in), .print_strobe_in(print_strobe_out),
    .key_strobe_out(key_strobe_in), .key_char_out(key_char_in), .req_btn_out(req_btn_in),
    .rel_btn_out(rel_btn_in));

  // 250 MHz clock
  initial begin
    clk_sys_in = 1'b0;
    forever #2 clk_sys_in = ~clk_sys_in;
  end

  task automatic end_sim();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask

  // One-cycle command pulse; returns just after the taking edge
  task automatic cmd(input ctb_op_type op, input logic [5:0] ch, input logic [3:0] ar);
    @(posedge clk_sys_in);
    #1;
    cmd_in = {1'b1, op, ch, ar};
    @(posedge clk_sys_in);
    #1;
    cmd_in.valid = 1'b0;
  endtask

  // Bounded wait for one indicator bit (2 type, 1 request, 0 release)
  task automatic wait_flag(input int idx, input int lim, output int n);
    n = 0;
    while (indicators_out[idx] !== 1'b1 && n < lim) begin
      @(posedge clk_sys_in);
      #1;
      n++;
    end
    if (indicators_out[idx] !== 1'b1) begin
      n_errors++;
      end_sim();
    end
  endtask

  // Main sequence: reset, printing, buttons, keyboard with type-ahead
  initial begin
    int         n;
    int         np;
    logic [5:0] c;
    logic [3:0] a;
    logic [5:0] tbl[4];
    tbl = '{6'h13, 6'h23, 6'h2E, 6'h3E};
    void'($urandom(32'hD608));
    cmd_in = '0;
    online_in = 1'b1;
    rst_n_in = 1'b0;
    wait_cyc(16);
    rst_n_in = 1'b1;
    wait_cyc(1);
    chk({indicators_out, contingency_out, keyboard_active_out, fetch_valid_out}, 16'h0);
    wait_cyc(3);
    // Controls first, then random characters; a second print while busy is dropped
    for (int i = 0; i < 7; i++) begin
      c = (i < 4) ? tbl[i] : 6'($urandom());
      cmd(CTB_OP_CLR_TYPE, 6'h00, 4'h0);
      cmd(CTB_OP_PRINT, c, 4'h0);
      buf_m = c;
      chk(print_strobe_out, 1'b1);
      chk(print_char_out, c);
      chk(print_ctrl_out, {c == 6'h13, c == 6'h23, c == 6'h2E, c == 6'h3E});
      cmd(CTB_OP_PRINT, ~c, 4'h0);
      chk({print_strobe_out, print_busy_out, print_char_out}, {2'b01, c});
      wait_flag(2, P + 10, n);
      // P busy cycles plus the flag edge, less the two edges spent on the dropped print
      chk(n, P - 1);
      chk(contingency_out, 1'b1);
      a = 4'($urandom());
      cmd(CTB_OP_FETCH, 6'h00, a);
      chk({fetch_valid_out, fetch_ar_out, fetch_char_out}, {1'b1, a, buf_m});
    end
    wait_cyc(5);
    chk(indicators_out.type_done, 1'b1);
    cmd(CTB_OP_FETCH, 6'h00, 4'h1);
    chk(fetch_char_out, buf_m);
    cmd(CTB_OP_CLR_TYPE, 6'h00, 4'h0);
    // Request button off-line, then on-line
    online_in = 1'b0;
    wait_cyc(4);
    i_console.press(1'b0);
    wait_cyc(4);
    chk({indicators_out, contingency_out}, 4'h0);
    online_in = 1'b1;
    wait_cyc(4);
    i_console.press(1'b0);
    wait_flag(1, 20, n);
    chk(contingency_out, 1'b1);
    cmd(CTB_OP_CLR_REQ, 6'h00, 4'h0);
    chk({indicators_out, contingency_out}, 4'h0);
    // Off-line key ignored, then nine keys unarmed: eight queue, one lost
    online_in = 1'b0;
    wait_cyc(4);
    i_console.key(6'h15);
    online_in = 1'b1;
    wait_cyc(4);
    np = i_console.prints;
    for (int i = 0; i < 9; i++) begin
      c = 6'($urandom());
      i_console.key(c);
      if (i < 8) begin
        kq.push_back(c);
      end
    end
    chk(key_ready_out, 1'b0);
    chk(i_console.prints, np);
    chk(indicators_out.type_done, 1'b0);
    // Drain one character per arm, in order
    while (kq.size() > 0) begin
      cmd(CTB_OP_ARM, 6'h00, 4'h0);
      chk(keyboard_active_out, 1'b1);
      wait_flag(2, 20, n);
      chk(keyboard_active_out, 1'b0);
      c = kq.pop_front();
      cmd(CTB_OP_FETCH, 6'h00, 4'h3);
      chk(fetch_char_out, c);
      cmd(CTB_OP_CLR_TYPE, 6'h00, 4'h0);
    end
    chk(key_ready_out, 1'b1);
    // Armed with nothing queued: lamp stays lit until release
    cmd(CTB_OP_ARM, 6'h00, 4'h0);
    wait_cyc(10);
    chk({indicators_out.type_done, keyboard_active_out}, 2'b01);
    i_console.press(1'b1);
    wait_flag(0, 20, n);
    chk({keyboard_active_out, contingency_out}, 2'b01);
    cmd(CTB_OP_CLR_REL, 6'h00, 4'h0);
    // A live keystroke while armed
    cmd(CTB_OP_ARM, 6'h00, 4'h0);
    c = 6'($urandom());
    i_console.key(c);
    wait_flag(2, 20, n);
    cmd(CTB_OP_FETCH, 6'h00, 4'h9);
    chk({fetch_char_out, keyboard_active_out}, {c, 1'b0});
    end_sim();
  end
endmodule // test_ctb_typewriter

`default_nettype wire
